//--- mcs_defs.svh
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MCS_ADDR_INIT_STATUS 8'h02
`define MCS_ADDR_FLAGS       8'h03
`define MCS_ADDR_DIAG_HI     8'h16
`define MCS_ADDR_DIAG_LO     8'h17
`define MCS_ADDR_POWER_CTL   8'h5d
`define MCS_ADDR_ID_BASE     8'h80

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MCS_BIT_DNR          0
`define MCS_BIT_PWR_OVERRIDE 0
`define MCS_BIT_PWR_SET      1
`define MCS_BIT_HP_CLASS     2
`define MCS_PWR_CTL_RESET    3'h0
`define MCS_FLAGS_RESET      8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCS_CLK_NS           25
`define MCS_RESET_PULSE_NS   10000
`define MCS_INIT_NS          2000000

`endif

//--- mcs_pkg.sv
package mcs_pkg;

  // ----------------------------------------------------------------
  // Register access from the serial engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcs_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } mcs_rsp_s;

  // ----------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_LOWQ = 2'b01,
    ST_HELD = 2'b10,
    ST_INIT = 2'b11
  } mcs_state_e;

endpackage

//--- mcs_sideband.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
// Summary of operation
// - Register requests are served while the module select pin is low.
// - With select high, no request is taken and the data line is never driven.
// - Select input idles high, so an undriven pin leaves the module deselected.
// - Reset input idles high, so an undriven pin keeps the module running.
// - Reset low beyond the minimum pulse returns all user settings to defaults.
// - Initialisation interval starts at the rising edge ending the reset pulse.
// - After initialisation attention goes low with data-not-ready cleared.
// - Power-up posts the same completion attention without a reset pulse.
// - Low-power input idles high; a high level requests low-power mode.
// - Power mode follows the pin plus override, power-set and high-class bits.
// - Presence output is tied low; the host pulls it up.
// - Attention goes low for any latched fault or status flag.
// - Completion attention clears once status read with zero and flags read.
// - Identification bytes and live diagnostics are readable over the bus.
module mcs_sideband
  import mcs_pkg::*;
#(
  parameter int                RESET_PULSE_NS = `MCS_RESET_PULSE_NS,
  parameter int                INIT_NS        = `MCS_INIT_NS,
  parameter int                FLAG_W         = 8,
  parameter logic [128*8-1:0]  ID_CONTENTS    = '0
) (
  input  wire logic            clk_sys,
  input  wire logic            sys_rst,
  input  wire logic            module_select_n,
  input  wire logic            module_reset_n,
  input  wire logic            low_power_request,
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  input  wire logic            sda_pull_req,
  input  wire mcs_req_s        reg_req,
  input  wire logic [FLAG_W-1:0] fault_event,
  input  wire logic [15:0]     diag_value,
  output logic                 scl_sync,
  output logic                 sda_sync,
  output logic                 scl_rise,
  output logic                 scl_fall,
  output logic                 bus_selected,
  output logic                 sda_out,
  output logic                 sda_oe_n,
  output mcs_rsp_s             reg_rsp,
  output logic                 attention_n_out,
  output logic                 attention_n_oe_n,
  output logic                 presence_detect_n,
  output logic                 low_power_active,
  output logic                 high_class_active,
  output logic                 module_in_reset
);
  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int RST_CYC_RAW  = (RESET_PULSE_NS + `MCS_CLK_NS - 1) / `MCS_CLK_NS;
  localparam int RST_CYC      = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
  localparam int INIT_CYC_RAW = INIT_NS / `MCS_CLK_NS;
  localparam int INIT_CYC     = (INIT_CYC_RAW < 1) ? 1 : INIT_CYC_RAW;
  localparam int CNT_MAX      = (RST_CYC > INIT_CYC) ? RST_CYC : INIT_CYC;
  localparam int CW           = $clog2(CNT_MAX + 1);
  if (FLAG_W < 1 || FLAG_W > 8 || RESET_PULSE_NS < 1 || INIT_NS < 1) begin : g_chk_param
    $error("FLAG_W must be 1 to 8 and timing parameters positive");
  end
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic       scl_prev_r;
  assign pin_raw = {sda_in, scl_in, low_power_request, module_reset_n, module_select_n};
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_s1_r   <= 5'h1f;
      pin_s2_r   <= 5'h1f;
      scl_prev_r <= 1'b1;
    end else begin
      pin_s1_r   <= pin_raw;
      pin_s2_r   <= pin_s1_r;
      scl_prev_r <= pin_s2_r[3];
    end
  end
  logic sel_n_s;
  logic rst_n_s;
  logic lp_s;
  assign sel_n_s  = pin_s2_r[0];
  assign rst_n_s  = pin_s2_r[1];
  assign lp_s     = pin_s2_r[2];
  assign scl_sync = pin_s2_r[3];
  assign sda_sync = pin_s2_r[4];
  assign scl_rise = pin_s2_r[3] & ~scl_prev_r;
  assign scl_fall = ~pin_s2_r[3] & scl_prev_r;
  // ----------------------------------------------------------------
  // Select gating of the serial bus
  // ----------------------------------------------------------------
  logic req_taken;
  assign bus_selected = ~sel_n_s;
  assign sda_out      = 1'b0;
  assign sda_oe_n     = ~(bus_selected & sda_pull_req);
  assign req_taken    = reg_req.valid & bus_selected;
  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  mcs_state_e    state_r;
  mcs_state_e    state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          init_done;
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    init_done = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (!rst_n_s) begin
          state_nxt = ST_LOWQ;
          cnt_nxt   = CW'(1);
        end
      end
      ST_LOWQ: begin
        if (rst_n_s) begin
          state_nxt = ST_RUN;
        end else if (cnt_r >= CW'(RST_CYC)) begin
          state_nxt = ST_HELD;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      ST_HELD: begin
        if (rst_n_s) begin
          state_nxt = ST_INIT;
          cnt_nxt   = '0;
        end
      end
      ST_INIT: begin
        if (!rst_n_s) begin
          state_nxt = ST_LOWQ;
          cnt_nxt   = CW'(1);
        end else if (cnt_r >= CW'(INIT_CYC - 1)) begin
          state_nxt = ST_RUN;
          init_done = 1'b1;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: begin
        state_nxt = ST_INIT;
        cnt_nxt   = '0;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_INIT;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end
  logic dnr;
  assign dnr             = (state_r == ST_HELD) || (state_r == ST_INIT);
  assign module_in_reset = dnr;
  // ----------------------------------------------------------------
  // Registers, flags and completion attention
  // ----------------------------------------------------------------
  logic [2:0]        pwr_r;
  logic [2:0]        pwr_nxt;
  logic [FLAG_W-1:0] flag_r;
  logic [FLAG_W-1:0] flag_nxt;
  logic              cmpl_r;
  logic              cmpl_nxt;
  logic              dnr_seen_r;
  logic              dnr_seen_nxt;
  logic              flag_seen_r;
  logic              flag_seen_nxt;
  mcs_rsp_s          rsp_r;
  mcs_rsp_s          rsp_nxt;
  logic              rd;
  logic              wr;
  logic              rd_status;
  logic              rd_flags;
  logic [7:0]        rdata;
  logic [6:0]        id_idx;
  assign rd        = req_taken & ~reg_req.write;
  assign wr        = req_taken & reg_req.write;
  assign rd_status = rd && (reg_req.addr == `MCS_ADDR_INIT_STATUS);
  assign rd_flags  = rd && (reg_req.addr == `MCS_ADDR_FLAGS);
  assign id_idx    = reg_req.addr[6:0];
  always_comb begin
    rdata = 8'h00;
    if (reg_req.addr == `MCS_ADDR_INIT_STATUS) begin
      rdata[`MCS_BIT_DNR] = dnr;
    end else if (reg_req.addr == `MCS_ADDR_FLAGS) begin
      rdata[FLAG_W-1:0] = flag_r;
    end else if (reg_req.addr == `MCS_ADDR_DIAG_HI) begin
      rdata = diag_value[15:8];
    end else if (reg_req.addr == `MCS_ADDR_DIAG_LO) begin
      rdata = diag_value[7:0];
    end else if (reg_req.addr == `MCS_ADDR_POWER_CTL) begin
      rdata[2:0] = pwr_r;
    end else if (reg_req.addr >= `MCS_ADDR_ID_BASE) begin
      rdata = ID_CONTENTS[id_idx*8 +: 8];
    end
  end
  always_comb begin
    pwr_nxt       = pwr_r;
    flag_nxt      = flag_r;
    cmpl_nxt      = cmpl_r;
    dnr_seen_nxt  = dnr_seen_r;
    flag_seen_nxt = flag_seen_r;
    rsp_nxt       = '0;
    if (req_taken) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.rdata = reg_req.write ? 8'h00 : rdata;
    end
    if (wr && reg_req.addr == `MCS_ADDR_POWER_CTL) begin
      pwr_nxt = reg_req.wdata[2:0];
    end
    if (rd_flags) begin
      flag_nxt = '0;
    end
    flag_nxt = flag_nxt | fault_event;
    if (cmpl_r) begin
      if (rd_status && !dnr) begin
        dnr_seen_nxt = 1'b1;
      end
      if (rd_flags) begin
        flag_seen_nxt = 1'b1;
      end
      if (dnr_seen_nxt && flag_seen_nxt) begin
        cmpl_nxt = 1'b0;
      end
    end
    if (dnr) begin
      pwr_nxt       = `MCS_PWR_CTL_RESET;
      flag_nxt      = FLAG_W'(`MCS_FLAGS_RESET);
      cmpl_nxt      = init_done;
      dnr_seen_nxt  = 1'b0;
      flag_seen_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pwr_r       <= `MCS_PWR_CTL_RESET;
      flag_r      <= FLAG_W'(`MCS_FLAGS_RESET);
      cmpl_r      <= 1'b0;
      dnr_seen_r  <= 1'b0;
      flag_seen_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      pwr_r       <= pwr_nxt;
      flag_r      <= flag_nxt;
      cmpl_r      <= cmpl_nxt;
      dnr_seen_r  <= dnr_seen_nxt;
      flag_seen_r <= flag_seen_nxt;
      rsp_r       <= rsp_nxt;
    end
  end
  assign reg_rsp = rsp_r;
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic lp_nxt;
  logic hc_nxt;
  logic attn_r;
  logic lp_r;
  logic hc_r;
  always_comb begin
    if (pwr_r[`MCS_BIT_PWR_OVERRIDE]) begin
      lp_nxt = pwr_r[`MCS_BIT_PWR_SET];
    end else begin
      lp_nxt = lp_s;
    end
    hc_nxt = ~lp_nxt & pwr_r[`MCS_BIT_HP_CLASS];
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      attn_r <= 1'b0;
      lp_r   <= 1'b1;
      hc_r   <= 1'b0;
    end else begin
      attn_r <= cmpl_nxt | (|flag_nxt);
      lp_r   <= lp_nxt;
      hc_r   <= hc_nxt;
    end
  end
  assign attention_n_out   = 1'b0;
  assign attention_n_oe_n  = ~attn_r;
  assign presence_detect_n = 1'b0;
  assign low_power_active  = lp_r;
  assign high_class_active = hc_r;
endmodule // mcs_sideband

//--- mcs_sideband_props.sv
`timescale 1ns/1ps
module mcs_sideband_props
  import mcs_pkg::*;
#(
  parameter int FLAG_W = 8
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              module_select_n,
  input wire logic              module_reset_n,
  input wire mcs_req_s          reg_req,
  input wire logic [FLAG_W-1:0] fault_event,
  input wire logic              bus_selected,
  input wire logic              sda_oe_n,
  input wire mcs_rsp_s          reg_rsp,
  input wire logic              attention_n_oe_n,
  input wire logic              presence_detect_n,
  input wire logic              module_in_reset
);
  // ----
  // Port checks
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_drive_sel;
    !sda_oe_n |-> bus_selected;
  endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("sda driven unselected");

  property p_desel_sync;
    module_select_n [*3] |-> !bus_selected;
  endproperty
  a_desel_sync: assert property (p_desel_sync) else $error("select not dropped");

  property p_req_taken;
    reg_req.valid && bus_selected |=> reg_rsp.valid;
  endproperty
  a_req_taken: assert property (p_req_taken) else $error("request not answered");

  property p_rsp_cause;
    reg_rsp.valid |-> $past(reg_req.valid && bus_selected);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without request");

  property p_dnr_read;
    reg_req.valid && bus_selected && !reg_req.write && reg_req.addr == 8'h02
      |=> reg_rsp.rdata[0] == $past(module_in_reset);
  endproperty
  a_dnr_read: assert property (p_dnr_read) else $error("not-ready bit wrong");

  property p_held_quiet;
    module_in_reset && $past(module_in_reset) && $past(module_in_reset, 2) |-> attention_n_oe_n;
  endproperty
  a_held_quiet: assert property (p_held_quiet) else $error("attention during reset");

  property p_done_attn;
    $fell(module_in_reset) && $past(module_reset_n, 3) |-> ##[0:2] !attention_n_oe_n;
  endproperty
  a_done_attn: assert property (p_done_attn) else $error("no completion attention");

  property p_fault_attn;
    (|fault_event) && !module_in_reset |-> ##[1:2] !attention_n_oe_n;
  endproperty
  a_fault_attn: assert property (p_fault_attn) else $error("fault not flagged");

  property p_present;
    presence_detect_n == 1'b0;
  endproperty
  a_present: assert property (p_present) else $error("presence not low");
endmodule // mcs_sideband_props

bind mcs_sideband mcs_sideband_props #(.FLAG_W(FLAG_W)) u_props (.*);

//--- mcs_host_model.sv
`timescale 1ns/1ps
module mcs_host_model #(
  parameter int SEL_CYC = 4
) (
  input  wire logic clk_sys,
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  input  wire logic attention_n_out,
  input  wire logic attention_n_oe_n,
  input  wire logic presence_detect_n,
  output logic      module_select_n,
  output logic      module_reset_n,
  output logic      low_power_request,
  output logic      scl_in,
  output logic      sda_in,
  output logic      attn_line,
  output logic      present_line
);
  // ----
  // Host pins with board pull-ups
  // ----
  logic scl_drv;
  initial begin
    module_select_n = 1'b1;
    module_reset_n = 1'b1;
    low_power_request = 1'b1;
    scl_drv = 1'b1;
  end
  assign scl_in = scl_drv;
  assign sda_in = sda_oe_n | sda_out;
  assign attn_line = attention_n_oe_n | attention_n_out;
  assign present_line = presence_detect_n;

  task automatic sel(input logic v);
    @(posedge clk_sys) module_select_n <= v;
    repeat (SEL_CYC) @(posedge clk_sys);
  endtask
  task automatic rst(input int n);
    @(posedge clk_sys) module_reset_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    module_reset_n <= 1'b1;
  endtask
  task automatic lp(input logic v);
    @(posedge clk_sys) low_power_request <= v;
  endtask
  task automatic frame(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_sys);
      scl_drv <= 1'b0;
      repeat (4) @(posedge clk_sys);
      scl_drv <= 1'b1;
    end
  endtask
endmodule // mcs_host_model

//--- mcs_sideband_tb_top.sv
`timescale 1ns/1ps
module mcs_sideband_tb_top;
  import mcs_pkg::*;
  localparam int INIT_CYC = 20;
  logic        clk_sys;
  logic        sys_rst;
  logic        sda_pull_req;
  mcs_req_s    reg_req;
  logic [7:0]  fault_event;
  logic [15:0] diag_value;
  logic       module_select_n, module_reset_n, low_power_request, scl_in, sda_in;
  logic       scl_sync, sda_sync, scl_rise, scl_fall, bus_selected, sda_out, sda_oe_n;
  mcs_rsp_s   reg_rsp;
  logic       attention_n_out, attention_n_oe_n, presence_detect_n, attn_line, present_line;
  logic       low_power_active, high_class_active, module_in_reset;
  int         errors = 0;
  int         num_checks = 0;
  int         rises = 0;
  int         falls = 0;
  int         base_f;
  int         cnt;
  logic [7:0] ctl [6] = '{8'h00, 8'h00, 8'h04, 8'h03, 8'h05, 8'h07};
  logic [2:0] exp [6] = '{3'b110, 3'b000, 3'b001, 3'b010, 3'b101, 3'b110};

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (scl_rise === 1'b1) rises <= rises + 1;
  always @(posedge clk_sys) if (scl_fall === 1'b1) falls <= falls + 1;

  mcs_sideband #(.RESET_PULSE_NS(100), .INIT_NS(500), .ID_CONTENTS(1024'h3c)) dut (.*);
  mcs_host_model host (.*);

  // ----
  // Access and check tasks
  // ----
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic v, input logic [7:0] e);
    @(posedge clk_sys) reg_req <= '{1'b1, w, a, d};
    @(posedge clk_sys) reg_req.valid <= 1'b0;
    #1;
    chk("rsp valid", {7'h0, v}, {7'h0, reg_rsp.valid});
    if (v) chk("rdata", e, reg_rsp.rdata);
  endtask
  task automatic wait_attn(input int lim);
    cnt = 0;
    while (attn_line !== 1'b0 && cnt < lim) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    chk("attention", 8'h00, {7'h0, attn_line});
  endtask
  task automatic idle_attn();
    repeat (2) @(posedge clk_sys);
    #1 chk("attention", 8'h01, {7'h0, attn_line});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    wrap_up();
  end

  // ----
  // Tests
  // ----
  initial begin
    clk_sys      = 1'b0;
    sys_rst      = 1'b1;
    sda_pull_req = 1'b0;
    reg_req      = '0;
    fault_event  = 8'h00;
    diag_value   = 16'h0000;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    host.sel(1'b0);
    acc(1'b0, 8'h02, 8'h00, 1'b1, 8'h01);
    wait_attn(INIT_CYC + 10);
    acc(1'b0, 8'h02, 8'h00, 1'b1, 8'h00);
    chk("attention", 8'h00, {7'h0, attn_line});
    acc(1'b0, 8'h03, 8'h00, 1'b1, 8'h00);
    idle_attn();
    $display("test power-up done");
    host.sel(1'b1);
    acc(1'b0, 8'h02, 8'h00, 1'b0, 8'h00);
    acc(1'b1, 8'h5d, 8'h07, 1'b0, 8'h00);
    @(posedge clk_sys) sda_pull_req <= 1'b1;
    #1 chk("sda line", 8'h01, {7'h0, sda_in});
    host.sel(1'b0);
    #1 chk("sda line", 8'h00, {7'h0, sda_in});
    chk("sda sync", 8'h00, {7'h0, sda_sync});
    @(posedge clk_sys) sda_pull_req <= 1'b0;
    acc(1'b0, 8'h5d, 8'h00, 1'b1, 8'h00);
    chk("presence", 8'h00, {7'h0, present_line});
    $display("test select done");
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 8'h5d, ctl[i], 1'b1, 8'h00);
      acc(1'b0, 8'h5d, 8'h00, 1'b1, ctl[i]);
      host.lp(exp[i][2]);
      repeat (4) @(posedge clk_sys);
      #1 chk("low power", {7'h0, exp[i][1]}, {7'h0, low_power_active});
      chk("high class", {7'h0, exp[i][0]}, {7'h0, high_class_active});
    end
    $display("test power done");
    @(posedge clk_sys) fault_event <= 8'h05;
    @(posedge clk_sys) fault_event <= 8'h00;
    wait_attn(6);
    acc(1'b0, 8'h03, 8'h00, 1'b1, 8'h05);
    idle_attn();
    acc(1'b0, 8'h03, 8'h00, 1'b1, 8'h00);
    $display("test fault done");
    host.rst(2);
    repeat (8) @(posedge clk_sys);
    acc(1'b0, 8'h5d, 8'h00, 1'b1, 8'h07);
    host.rst(12);
    #1 chk("in reset", 8'h01, {7'h0, module_in_reset});
    cnt = 0;
    while (module_in_reset !== 1'b0 && cnt < 100) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    chk("init length", 8'h01, {7'h0, (cnt >= INIT_CYC && cnt <= INIT_CYC + 4)});
    wait_attn(4);
    acc(1'b0, 8'h5d, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 8'h02, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 8'h03, 8'h00, 1'b1, 8'h00);
    idle_attn();
    $display("test reset done");
    diag_value <= 16'ha55a;
    acc(1'b0, 8'h16, 8'h00, 1'b1, 8'ha5);
    acc(1'b0, 8'h17, 8'h00, 1'b1, 8'h5a);
    acc(1'b0, 8'h80, 8'h00, 1'b1, 8'h3c);
    acc(1'b0, 8'h40, 8'h00, 1'b1, 8'h00);
    acc(1'b1, 8'h02, 8'hff, 1'b1, 8'h00);
    acc(1'b0, 8'h02, 8'h00, 1'b1, 8'h00);
    cnt = rises;
    base_f = falls;
    host.frame(4);
    repeat (4) @(posedge clk_sys);
    #1 chk("scl rises", 8'h04, 8'(rises - cnt));
    chk("scl falls", 8'h04, 8'(falls - base_f));
    chk("scl level", 8'h01, {7'h0, scl_sync});
    $display("test memory done");
    wrap_up();
  end
endmodule // mcs_sideband_tb_top
